// ==== core/aec_extra_conv.v ====
// Function
// - Bits 7:6 select the extra conversion reference: internal, input 7, supply, 6-7 diff.
// - Bits 5:4 select decimation 64/128/256/512, giving 8/10/12/14-bit results.
// - Bits 3:0 select channel; codes 0000-0110 are single-ended inputs 0-6.
// - After a conversion sequence ends, run one extra conversion with extra settings.
// - An extra conversion is scheduled only after software writes the channel field.
// - Writing the channel field while the converter is idle starts a conversion at once.
// - The channel field clears to zero when the extra conversion completes with no newer request written during the run.
// - Codes 0111-1111: input 7, four differential pairs, ground, reference, temp, supply/3.
`include "aec_consts.vh"

module aec_extra_conv #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite register slave
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  // Converter core status
  input  wire          conv_busy,
  input  wire          seq_done,
  input  wire          conv_done,
  // Converter core control for the extra conversion
  output reg           extra_start,
  output reg           extra_active,
  output reg  [1:0]    extra_reference_select,
  output reg  [1:0]    extra_decimation_select,
  output reg  [3:0]    extra_channel_select,
  output reg  [9:0]    extra_dec_rate,
  output reg  [3:0]    extra_res_bits,
  output reg           extra_diff,
  output reg           extra_internal,
  output reg  [2:0]    extra_pos_input,
  output reg  [2:0]    extra_neg_input
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_WAIT = 3'b010;
  localparam [2:0] S_RUN  = 3'b100;

  reg  [2:0]    state_q;
  reg  [2:0]    state_d;
  reg  [1:0]    ref_q;
  reg  [1:0]    dec_q;
  reg  [3:0]    ch_q;
  reg           pending_q;
  reg           start_d;
  reg  [31:0]   rd_data;
  reg           rd_ok;

  wire          wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0]   wr_data;
  wire [3:0]    wr_strb;
  wire [AW-1:0] rd_addr;
  wire          hit_ctrl_w;
  wire          ctrl_wr;
  wire          wr_ok;
  wire [1:0]    ref_n;
  wire [1:0]    dec_n;
  wire [3:0]    ch_n;

  aec_axil_slave #(
    .AW (AW)
  ) u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_axi_awaddr),
    .s_awvalid (s_axi_awvalid),
    .s_awready (s_axi_awready),
    .s_wdata   (s_axi_wdata),
    .s_wstrb   (s_axi_wstrb),
    .s_wvalid  (s_axi_wvalid),
    .s_wready  (s_axi_wready),
    .s_bresp   (s_axi_bresp),
    .s_bvalid  (s_axi_bvalid),
    .s_bready  (s_axi_bready),
    .s_araddr  (s_axi_araddr),
    .s_arvalid (s_axi_arvalid),
    .s_arready (s_axi_arready),
    .s_rdata   (s_axi_rdata),
    .s_rresp   (s_axi_rresp),
    .s_rvalid  (s_axi_rvalid),
    .s_rready  (s_axi_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // Status register is read-only; writes to it are accepted and dropped
  assign hit_ctrl_w = (wr_addr == `AEC_CTRL_ADDR);
  assign wr_ok      = hit_ctrl_w | (wr_addr == `AEC_STAT_ADDR);
  // Register lives in byte lane 0 only
  assign ctrl_wr    = wr_en & hit_ctrl_w & wr_strb[0];
  // Fields as they stand after this edge: a write that starts a run at once must use its own values
  assign ref_n      = ctrl_wr ? wr_data[`AEC_REF_MSB:`AEC_REF_LSB] : ref_q;
  assign dec_n      = ctrl_wr ? wr_data[`AEC_DEC_MSB:`AEC_DEC_LSB] : dec_q;
  assign ch_n       = ctrl_wr ? wr_data[`AEC_CH_MSB:`AEC_CH_LSB] : ch_q;

  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_addr == `AEC_CTRL_ADDR) begin
      rd_data[7:0] = {ref_q, dec_q, ch_q};
    end else if (rd_addr == `AEC_STAT_ADDR) begin
      rd_data[4:0] = {conv_busy, state_q == S_RUN, pending_q, state_q[2:1]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Sequencing of the extra conversion
  always @* begin
    state_d = state_q;
    start_d = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (ctrl_wr) begin
          if (!conv_busy) begin
            state_d = S_RUN;
            start_d = 1'b1;
          end else begin
            state_d = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // An idle converter with no sequence end still serves the request
        if (seq_done || !conv_busy) begin
          state_d = S_RUN;
          start_d = 1'b1;
        end
      end
      S_RUN: begin
        if (conv_done) begin
          if (pending_q || ctrl_wr) begin
            state_d = S_WAIT;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= S_IDLE;
      ref_q       <= `AEC_REF_RESET;
      dec_q       <= `AEC_DEC_RESET;
      ch_q        <= `AEC_CH_CLEARED;
      pending_q   <= 1'b0;
      extra_start <= 1'b0;
    end else begin
      state_q     <= state_d;
      extra_start <= start_d;
      if (ctrl_wr) begin
        ref_q <= wr_data[`AEC_REF_MSB:`AEC_REF_LSB];
        dec_q <= wr_data[`AEC_DEC_MSB:`AEC_DEC_LSB];
        ch_q  <= wr_data[`AEC_CH_MSB:`AEC_CH_LSB];
      end else if (state_q == S_RUN && conv_done && !pending_q) begin
        // A newer request written during the run keeps its channel
        ch_q <= `AEC_CH_CLEARED;
      end
      // Written request in the run phase is remembered for the next slot
      if (ctrl_wr && state_q == S_RUN) begin
        pending_q <= 1'b1;
      end else if (state_q == S_IDLE || start_d) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Settings are frozen at start so software rewrites cannot disturb a run
  always @(posedge aclk) begin
    if (!aresetn) begin
      extra_active            <= 1'b0;
      extra_reference_select  <= 2'b00;
      extra_decimation_select <= 2'b00;
      extra_channel_select    <= 4'h0;
    end else begin
      extra_active <= (state_d == S_RUN);
      if (start_d) begin
        extra_reference_select  <= ref_n;
        extra_decimation_select <= dec_n;
        extra_channel_select    <= ch_n;
      end
    end
  end

  // Decoded views of the frozen settings
  always @(posedge aclk) begin
    if (!aresetn) begin
      extra_dec_rate  <= `AEC_RATE_64;
      extra_res_bits  <= `AEC_RES_8;
      extra_diff      <= 1'b0;
      extra_internal  <= 1'b0;
      extra_pos_input <= 3'h0;
      extra_neg_input <= 3'h0;
    end else if (start_d) begin
      case (dec_n)
        2'b00:   begin extra_dec_rate <= `AEC_RATE_64;  extra_res_bits <= `AEC_RES_8;  end
        2'b01:   begin extra_dec_rate <= `AEC_RATE_128; extra_res_bits <= `AEC_RES_10; end
        2'b10:   begin extra_dec_rate <= `AEC_RATE_256; extra_res_bits <= `AEC_RES_12; end
        default: begin extra_dec_rate <= `AEC_RATE_512; extra_res_bits <= `AEC_RES_14; end
      endcase
      // Single-ended 0..7, pairs 0-1..6-7, then internal sources
      extra_diff      <= (ch_n[3:2] == 2'b10);
      extra_internal  <= (ch_n[3:2] == 2'b11);
      if (!ch_n[3]) begin
        extra_pos_input <= ch_n[2:0];
        extra_neg_input <= 3'h0;
      end else if (!ch_n[2]) begin
        extra_pos_input <= {ch_n[1:0], 1'b0};
        extra_neg_input <= {ch_n[1:0], 1'b1};
      end else begin
        extra_pos_input <= {1'b0, ch_n[1:0]};
        extra_neg_input <= 3'h0;
      end
    end
  end

endmodule // aec_extra_conv

// ==== core/aec_consts.vh ====
`ifndef AEC_CONSTS_VH
`define AEC_CONSTS_VH

// Register indices; byte address is four times the index
`define AEC_CTRL_IDX        10'h0b6
`define AEC_STAT_IDX        10'h0b7
`define AEC_CTRL_ADDR       {`AEC_CTRL_IDX, 2'b00}
`define AEC_STAT_ADDR       {`AEC_STAT_IDX, 2'b00}

// Control register fields
`define AEC_REF_MSB         7
`define AEC_REF_LSB         6
`define AEC_DEC_MSB         5
`define AEC_DEC_LSB         4
`define AEC_CH_MSB          3
`define AEC_CH_LSB          0
`define AEC_CTRL_RESET      8'h00
`define AEC_CH_CLEARED      4'h0
`define AEC_REF_RESET       2'b00
`define AEC_DEC_RESET       2'b00

// Reference codes
`define AEC_REF_INT_1V25    2'b00
`define AEC_REF_EXT_IN7     2'b01
`define AEC_REF_SUPPLY      2'b10
`define AEC_REF_EXT_DIFF67  2'b11

// Decimation rates and resolutions
`define AEC_RATE_64         10'h040
`define AEC_RATE_128        10'h080
`define AEC_RATE_256        10'h100
`define AEC_RATE_512        10'h200
`define AEC_RES_8           4'h8
`define AEC_RES_10          4'ha
`define AEC_RES_12          4'hc
`define AEC_RES_14          4'he

// Bus responses
`define AEC_RESP_OKAY       2'b00
`define AEC_RESP_SLVERR     2'b10

`endif

// ==== core/aec_axil_slave.v ====
`include "aec_consts.vh"

module aec_axil_slave #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite write address, data and response
  input  wire [AW-1:0] s_awaddr,
  input  wire          s_awvalid,
  output wire          s_awready,
  input  wire [31:0]   s_wdata,
  input  wire [3:0]    s_wstrb,
  input  wire          s_wvalid,
  output wire          s_wready,
  output reg  [1:0]    s_bresp,
  output reg           s_bvalid,
  input  wire          s_bready,
  // AXI4-Lite read
  input  wire [AW-1:0] s_araddr,
  input  wire          s_arvalid,
  output wire          s_arready,
  output reg  [31:0]   s_rdata,
  output reg  [1:0]    s_rresp,
  output reg           s_rvalid,
  input  wire          s_rready,
  // Register side
  output wire          wr_en,
  output reg  [AW-1:0] wr_addr,
  output reg  [31:0]   wr_data,
  output reg  [3:0]    wr_strb,
  input  wire          wr_ok,
  output wire [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_ok
);

  reg aw_full_q;
  reg w_full_q;

  assign s_awready = ~aw_full_q & ~s_bvalid;
  assign s_wready  = ~w_full_q & ~s_bvalid;
  // Write commits once both halves are held, whichever came first
  assign wr_en     = aw_full_q & w_full_q & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign rd_addr   = s_araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      wr_addr   <= {AW{1'b0}};
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `AEC_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_q <= 1'b1;
        wr_addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full_q <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end
      if (wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `AEC_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_data;
      s_rresp  <= rd_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule // aec_axil_slave

// ==== tb/aec_extra_conv_sva.sv ====
module aec_extra_conv_sva (
  // Clock and reset
  input wire       aclk,
  input wire       aresetn,
  // Converter core side
  input wire       conv_busy,
  input wire       seq_done,
  input wire       conv_done,
  input wire       extra_start,
  input wire       extra_active,
  input wire [1:0] extra_decimation_select,
  input wire [3:0] extra_channel_select,
  input wire [9:0] extra_dec_rate,
  input wire [3:0] extra_res_bits,
  input wire       extra_diff,
  input wire [2:0] extra_pos_input,
  input wire [2:0] extra_neg_input
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rate; extra_dec_rate == (10'h040 << extra_decimation_select); endproperty
  property p_res; extra_res_bits == 4'h8 + {extra_decimation_select, 1'b0}; endproperty
  property p_pulse; extra_start |=> !extra_start; endproperty
  property p_cause; extra_start |-> $past(seq_done) || !$past(conv_busy); endproperty
  property p_active; extra_start |-> extra_active; endproperty
  property p_end; extra_active && conv_done |=> !extra_active || extra_start; endproperty
  property p_diff; extra_diff == (extra_channel_select[3:2] == 2'b10); endproperty
  property p_pair;
    extra_diff |-> extra_pos_input == {extra_channel_select[1:0], 1'b0}
      && extra_neg_input == {extra_channel_select[1:0], 1'b1};
  endproperty
  property p_single;
    !extra_channel_select[3] |-> extra_pos_input == extra_channel_select[2:0]
      && extra_neg_input == 3'h0;
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode wrong");
  a_res: assert property (p_res) else $error("resolution decode wrong");
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  a_cause: assert property (p_cause) else $error("start without idle or sequence end");
  a_active: assert property (p_active) else $error("start without active");
  a_end: assert property (p_end) else $error("active held after done");
  a_diff: assert property (p_diff) else $error("differential flag wrong");
  a_pair: assert property (p_pair) else $error("differential pair wrong");
  a_single: assert property (p_single) else $error("single-ended input wrong");
  c_seq: cover property (seq_done ##1 extra_start);
  c_done: cover property (extra_active && conv_done);
  c_diff: cover property (extra_start ##1 extra_diff);
endmodule // aec_extra_conv_sva

bind aec_extra_conv aec_extra_conv_sva u_aec_extra_conv_sva (.*);

// ==== tb/aec_extra_conv_bench.sv ====
`include "aec_consts.vh"
module aec_extra_conv_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, conv_busy = 0, seq_done = 0, conv_done = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0]  rsp;
  logic [7:0]  v;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, extra_reference_select, extra_decimation_select;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  extra_channel_select, extra_res_bits;
  wire  [9:0]  extra_dec_rate;
  wire  [2:0]  extra_pos_input, extra_neg_input;
  wire         extra_start, extra_active, extra_diff, extra_internal;
  int          fail_count = 0, checked = 0, starts = 0, cyc = 0, s;

  aec_extra_conv u_aec_extra_conv (.*);

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (extra_start === 1'b1) starts <= starts + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Requests change just after a rising edge; handshakes and answers are taken at rising edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!hb);
    s_axi_bready <= 0;
    @(negedge aclk);
  endtask

  task automatic rdt(input logic [11:0] a);
    logic hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!hr);
    s_axi_rready <= 0;
    @(negedge aclk);
  endtask

  function automatic logic [2:0] exp_pos(input logic [3:0] c);
    if (c[3:2] == 2'b10) return {c[1:0], 1'b0};
    return c[3] ? {1'b0, c[1:0]} : c[2:0];
  endfunction

  task automatic chk_out(input logic [7:0] d);
    logic [3:0] c;
    c = d[3:0];
    chk(extra_reference_select, d[7:6]);
    chk(extra_dec_rate, 10'h040 << d[5:4]);
    chk(extra_res_bits, 4'h8 + 2 * d[5:4]);
    chk(extra_channel_select, c);
    chk(extra_diff, c[3:2] == 2'b10);
    chk(extra_internal, c[3:2] == 2'b11);
    chk(extra_pos_input, exp_pos(c));
    chk(extra_neg_input, c[3:2] == 2'b10 ? {c[1:0], 1'b1} : 3'h0);
  endtask

  // Random run length so completion lands at varying distances from the start
  task automatic run_conv(input logic [7:0] d);
    @(posedge aclk);
    conv_busy <= 1;
    repeat ($urandom_range(1, 30)) @(posedge aclk);
    conv_done <= 1;
    conv_busy <= 0;
    @(posedge aclk);
    conv_done <= 0;
    rdt(`AEC_CTRL_ADDR);
    chk(rd, {24'h00_0000, d[7:4], 4'h0});
  endtask

  initial begin
    void'($urandom(32'h3405_7c3c));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rdt(`AEC_CTRL_ADDR);
    chk(rd, 32'h0000_0000);
    chk(extra_dec_rate, 10'h040);
    for (int i = 0; i < 16; i++) begin
      v = {i[1:0], i[3:2], i[3:0]};
      s = starts;
      wr(`AEC_CTRL_ADDR, v);
      chk(rsp, `AEC_RESP_OKAY);
      chk(starts, s + 1);
      chk_out(v);
      rdt(`AEC_CTRL_ADDR);
      chk(rd, {24'h00_0000, v});
      run_conv(v);
    end
    v = 8'h9b;
    @(posedge aclk);
    conv_busy <= 1;
    s = starts;
    wr(`AEC_CTRL_ADDR, v);
    // Busy converter: request waits, status shows waiting and busy
    rdt(`AEC_STAT_ADDR);
    chk(rd, 32'h0000_0011);
    repeat (6) @(posedge aclk);
    chk(starts, s);
    seq_done <= 1;
    @(posedge aclk);
    seq_done <= 0;
    repeat (2) @(negedge aclk);
    chk(starts, s + 1);
    chk_out(v);
    run_conv(v);
    @(posedge aclk);
    seq_done <= 1;
    @(posedge aclk);
    seq_done <= 0;
    repeat (3) @(negedge aclk);
    chk(starts, s + 1);
    wr(12'h000, 8'h05);
    chk(rsp, `AEC_RESP_SLVERR);
    wr(`AEC_STAT_ADDR, 8'h05);
    chk(rsp, `AEC_RESP_OKAY);
    rdt(12'h000);
    chk(rsp, `AEC_RESP_SLVERR);
    chk(starts, s + 1);
    rdt(`AEC_CTRL_ADDR);
    chk(rd, 32'h0000_0090);
    // Reset while idle must bring the register back to zero
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdt(`AEC_CTRL_ADDR);
    chk(rd, 32'h0000_0000);
    close_out;
  end
endmodule // aec_extra_conv_bench
